/* File: hdl/seb_pkg.sv */
// Shared constants for the two-wire EEPROM slave and its master
// Functional notes
// - SDA falling while SCL high is start
// - SDA rising while SCL high is stop
// - Stop during read returns device to idle
// - Stop during write starts internal programming; code does so only in ST_WEND, after the data byte, else goes idle
// - Data changes only while SCL low
// - Eight-bit units, receiver acks on ninth clock
// - No ack, bus ignored while programming
// - Master sends 7-bit address plus R/W first
// - Compare upper four bits, ignore next three; the 4K variant uses the third of them as the upper-256 select
// - Acknowledge matching device address on ninth clock
// - Seventh address bit selects upper 256 bytes
// - Write: accept and acknowledge 8-bit word address
// - Byte write: one data byte, ack, stop
// - Programming finishes within 10.0 ms
// - SDA driven low only, open drain
// - Write-protect blocks variant-dependent address range
// - Blocked write still runs program period
package seb_pkg;
   localparam int SEB_CLK_MHZ = 125;
   localparam int SEB_PROG_TIME_US = 10000;
   localparam int SEB_PROG_CYCLES = SEB_PROG_TIME_US * SEB_CLK_MHZ;
   localparam int SEB_BITS = 8;
   // Device-type code: value arbitrary
   localparam logic [3:0] SEB_TYPE_CODE = 4'h5;
   localparam logic [1:0] SEB_VAR_1K = 2'h0;
   localparam logic [1:0] SEB_VAR_2K = 2'h1;
   localparam logic [1:0] SEB_VAR_4K = 2'h2;
   localparam logic [8:0] SEB_WP_LO_2K = 9'h080;
   localparam logic [8:0] SEB_WP_LO_4K = 9'h100;
   localparam logic [8:0] SEB_WP_HI = 9'h1FF;
   localparam logic [8:0] SEB_WP_HI_2K = 9'h0FF;
   localparam int SEB_SCL_HALF = 32;
endpackage : seb_pkg

/* File: hdl/seb_if.sv */
// Two-wire link between master and EEPROM slave
`timescale 1ns/100ps
`default_nettype none
interface seb_if;
   logic scl;
   logic sda_m_oe_n;
   logic sda_s_oe_n;
   wire logic sda;
   assign sda = ~(~sda_m_oe_n | ~sda_s_oe_n);
   modport slave (input scl, input sda, output sda_s_oe_n);
   modport master (output scl, input sda, output sda_m_oe_n);
endinterface : seb_if
`default_nettype wire

/* File: hdl/seb_slave.sv */
// EEPROM two-wire slave front end with write-cycle timer
`timescale 1ns/100ps
`default_nettype none
module seb_slave #(
   parameter logic [1:0] VARIANT = seb_pkg::SEB_VAR_4K,
   parameter int PROG_CYCLES = seb_pkg::SEB_PROG_CYCLES
) (
   // System
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Link
   seb_if.slave bus,
   // User side
   input wire logic wp_i,
   output logic wr_stb_o,
   output logic [8:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic busy_o,
   output logic rd_req_o,
   input wire logic [7:0] rd_data_i
);
   import seb_pkg::*;
   initial begin
      if (PROG_CYCLES < 1) $error("PROG_CYCLES must be positive");
   end
   typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WADR, ST_WDAT, ST_WEND,
      ST_READ, ST_PROG} seb_st_t;
   seb_st_t st_r;
   logic [2:0] scl_s_r, sda_s_r;
   // Write-protect is a pin: two flops before use
   logic [1:0] wp_s_r;
   logic scl_d, sda_d, scl_q, sda_q;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic ack_r, mack_r, hi_r, got_r;
   logic [8:0] adr_r;
   logic [31:0] cnt_r;
   assign scl_d = scl_s_r[1];
   assign sda_d = sda_s_r[1];
   assign scl_q = scl_s_r[2];
   assign sda_q = sda_s_r[2];
   wire scl_rise = scl_d & ~scl_q;
   wire scl_fall = ~scl_d & scl_q;
   wire start_ev = scl_d & scl_q & sda_q & ~sda_d;
   wire stop_ev = scl_d & scl_q & ~sda_q & sda_d;
   function automatic logic prot(input logic [8:0] a);
      unique case (VARIANT)
         SEB_VAR_1K: prot = 1'b1;
         SEB_VAR_2K: prot = a >= SEB_WP_LO_2K && a <= SEB_WP_HI_2K;
         default: prot = a >= SEB_WP_LO_4K && a <= SEB_WP_HI;
      endcase
   endfunction : prot
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
         wp_s_r <= 2'h0;
      end else begin
         wp_s_r <= {wp_s_r[0], wp_i};
         scl_s_r <= {scl_s_r[1:0], bus.scl};
         sda_s_r <= {sda_s_r[1:0], bus.sda};
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= ST_IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         ack_r <= 1'b0;
         mack_r <= 1'b0;
         hi_r <= 1'b0;
         got_r <= 1'b0;
         adr_r <= 9'h000;
         cnt_r <= 32'h0;
         wr_stb_o <= 1'b0;
         wr_addr_o <= 9'h000;
         wr_data_o <= 8'h00;
         rd_req_o <= 1'b0;
         bus.sda_s_oe_n <= 1'b1;
      end else begin
         wr_stb_o <= 1'b0;
         rd_req_o <= 1'b0;
         if (st_r == ST_PROG) begin
            bus.sda_s_oe_n <= 1'b1;
            if (cnt_r >= 32'(PROG_CYCLES - 1)) begin
               st_r <= ST_IDLE;
               cnt_r <= 32'h0;
            end else begin
               cnt_r <= cnt_r + 32'h1;
            end
         end else if (start_ev) begin
            st_r <= ST_DEV;
            bit_r <= 4'h0;
            bus.sda_s_oe_n <= 1'b1;
         end else if (stop_ev) begin
            bus.sda_s_oe_n <= 1'b1;
            if (st_r == ST_WEND) begin
               st_r <= ST_PROG;
               cnt_r <= 32'h0;
               if (!(wp_s_r[1] && prot(wr_addr_o))) wr_stb_o <= 1'b1;
            end else begin
               st_r <= ST_IDLE;
            end
         end else if (st_r != ST_IDLE) begin
            if (scl_rise && bit_r < 4'd8) begin
               sh_r <= {sh_r[6:0], sda_d};
               bit_r <= bit_r + 4'h1;
            end else if (scl_rise && st_r == ST_READ) begin
               mack_r <= ~sda_d;
            end
            if (scl_fall) begin
               if (bit_r == 4'd8) begin
                  bit_r <= 4'd9;
                  ack_r <= 1'b1;
                  unique case (st_r)
                     ST_DEV: begin
                        if (sh_r[7:4] == SEB_TYPE_CODE) begin
                           bus.sda_s_oe_n <= 1'b0;
                           hi_r <= (VARIANT == SEB_VAR_4K) & sh_r[1];
                           got_r <= sh_r[0];
                        end else begin
                           st_r <= ST_IDLE;
                           ack_r <= 1'b0;
                        end
                     end
                     ST_WADR: begin
                        bus.sda_s_oe_n <= 1'b0;
                        adr_r <= {hi_r, sh_r};
                     end
                     ST_WDAT: begin
                        bus.sda_s_oe_n <= 1'b0;
                        wr_addr_o <= adr_r;
                        wr_data_o <= sh_r;
                     end
                     ST_READ: bus.sda_s_oe_n <= 1'b1;
                     default: ack_r <= 1'b0;
                  endcase
               end else if (bit_r == 4'd9) begin
                  bus.sda_s_oe_n <= 1'b1;
                  bit_r <= 4'h0;
                  ack_r <= 1'b0;
                  unique case (st_r)
                     ST_DEV: begin
                        st_r <= got_r ? ST_READ : ST_WADR;
                        if (got_r) begin
                           rd_req_o <= 1'b1;
                           sh_r <= rd_data_i;
                           bus.sda_s_oe_n <= rd_data_i[7];
                        end
                     end
                     ST_WADR: st_r <= ST_WDAT;
                     ST_WDAT: st_r <= ST_WEND;
                     ST_READ: begin
                        if (mack_r) begin
                           rd_req_o <= 1'b1;
                           sh_r <= rd_data_i;
                           bus.sda_s_oe_n <= rd_data_i[7];
                        end else begin
                           st_r <= ST_IDLE;
                        end
                     end
                     default: st_r <= ST_WEND;
                  endcase
               end else if (st_r == ST_READ && bit_r < 4'd8) begin
                  bus.sda_s_oe_n <= sh_r[7];
               end
            end
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) busy_o <= 1'b0;
      else busy_o <= (st_r == ST_PROG);
   end
endmodule : seb_slave
`default_nettype wire

/* File: hdl/seb_master.sv */
// Two-wire master issuing byte writes, SCL from a divider
`timescale 1ns/100ps
`default_nettype none
module seb_master #(
   parameter int HALF = seb_pkg::SEB_SCL_HALF
) (
   // System
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Link
   seb_if.master bus,
   // User side
   input wire logic go_i,
   input wire logic [6:0] dev_i,
   input wire logic [7:0] wadr_i,
   input wire logic [7:0] wdat_i,
   output logic busy_o,
   output logic nack_o
);
   import seb_pkg::*;
   initial begin
      if (HALF < 2) $error("HALF too small");
   end
   typedef enum logic [2:0] {M_IDLE, M_START, M_BITS, M_STOP, M_DONE} seb_m_t;
   seb_m_t st_r;
   logic [31:0] div_r;
   logic [1:0] ph_r;
   logic [4:0] nb_r;
   logic [3:0] bit_r;
   logic [23:0] sh_r;
   logic [1:0] sda_s_r;
   wire tick = div_r == 32'(HALF - 1);
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) sda_s_r <= 2'h3;
      else sda_s_r <= {sda_s_r[0], bus.sda};
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= M_IDLE;
         div_r <= 32'h0;
         ph_r <= 2'h0;
         nb_r <= 5'h0;
         bit_r <= 4'h0;
         sh_r <= 24'h0;
         busy_o <= 1'b0;
         nack_o <= 1'b0;
         bus.scl <= 1'b1;
         bus.sda_m_oe_n <= 1'b1;
      end else begin
         div_r <= tick ? 32'h0 : div_r + 32'h1;
         unique case (st_r)
            M_IDLE: if (go_i) begin
               st_r <= M_START;
               sh_r <= {dev_i, 1'b0, wadr_i, wdat_i};
               busy_o <= 1'b1;
               nack_o <= 1'b0;
               nb_r <= 5'h0;
               bit_r <= 4'h0;
               ph_r <= 2'h0;
               div_r <= 32'h0;
            end
            M_START: if (tick) begin
               bus.sda_m_oe_n <= 1'b0;
               st_r <= M_BITS;
            end
            M_BITS: if (tick) begin
               ph_r <= ph_r + 2'h1;
               unique case (ph_r)
                  2'h0: begin
                     bus.scl <= 1'b0;
                  end
                  2'h1: begin
                     bus.sda_m_oe_n <= (bit_r == 4'd8) ? 1'b1 : sh_r[23];
                  end
                  2'h2: begin
                     bus.scl <= 1'b1;
                  end
                  default: begin
                     if (bit_r == 4'd8) begin
                        if (sda_s_r[1]) nack_o <= 1'b1;
                        bit_r <= 4'h0;
                        nb_r <= nb_r + 5'h1;
                        if (sda_s_r[1] || nb_r == 5'd2) st_r <= M_STOP;
                     end else begin
                        bit_r <= bit_r + 4'h1;
                        sh_r <= {sh_r[22:0], 1'b0};
                     end
                  end
               endcase
            end
            M_STOP: if (tick) begin
               ph_r <= ph_r + 2'h1;
               unique case (ph_r)
                  2'h0: bus.scl <= 1'b0;
                  2'h1: bus.sda_m_oe_n <= 1'b0;
                  2'h2: bus.scl <= 1'b1;
                  default: begin
                     bus.sda_m_oe_n <= 1'b1;
                     st_r <= M_DONE;
                  end
               endcase
            end
            default: begin
               busy_o <= 1'b0;
               st_r <= M_IDLE;
            end
         endcase
      end
   end
endmodule : seb_master
`default_nettype wire

/* File: tb/seb_checker.sv */
// Link checker: acknowledge timing and bus release around frames
`timescale 1ns/100ps
`default_nettype none
module seb_checker #(
   parameter int PROG_CYCLES = 1000
) (
   // System
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Link
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_oe_n
);
   logic scl_r;
   logic sda_r;
   logic [3:0] bit_r;
   logic [1:0] ack_r;
   int prog_r;
   wire logic start = scl && scl_r && sda_r && !sda;
   wire logic stop = scl && scl_r && !sda_r && sda;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   // Window opens before the slave sees the stop, so it closes before busy ends
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         bit_r <= 4'h0;
         ack_r <= 2'h0;
         prog_r <= 0;
      end else begin
         scl_r <= scl;
         sda_r <= sda;
         if (start) begin
            bit_r <= 4'h0;
            ack_r <= 2'h0;
         end else if (scl && !scl_r) begin
            bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
         end
         if (!start && !sda_s_oe_n && sda_r && ack_r != 2'h3) begin
            ack_r <= ack_r + 2'h1;
         end
         if (stop && ack_r == 2'h3) begin
            prog_r <= PROG_CYCLES;
         end else if (prog_r != 0) begin
            prog_r <= prog_r - 1;
         end
      end
   end
   sequence s_ack_hold;
      (!sda_s_oe_n && scl) [*8];
   endsequence
   property p_ack_edge;
      $changed(sda_s_oe_n) |-> !scl;
   endproperty
   a_ack_edge: assert property (p_ack_edge) else $error("ack moved, scl high");
   property p_ack_hold;
      $rose(scl) && !sda_s_oe_n |-> s_ack_hold;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
   property p_ack_len;
      $fell(sda_s_oe_n) |-> ##[1:100] sda_s_oe_n;
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("ack held too long");
   property p_ack_ninth;
      $rose(scl) && !sda_s_oe_n |-> bit_r == 4'h8;
   endproperty
   a_ack_ninth: assert property (p_ack_ninth) else $error("ack off ninth");
   property p_mst_release;
      $rose(scl) && bit_r == 4'h8 |-> sda_m_oe_n;
   endproperty
   a_mst_release: assert property (p_mst_release) else $error("master held");
   property p_prog_quiet;
      prog_r != 0 |-> sda_s_oe_n;
   endproperty
   a_prog_quiet: assert property (p_prog_quiet) else $error("ack in busy");
   property p_start_free;
      start |-> sda_s_oe_n [*8];
   endproperty
   a_start_free: assert property (p_start_free) else $error("drive at start");
   property p_stop_idle;
      stop |-> scl [*4];
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("scl after stop");
endmodule : seb_checker
`default_nettype wire

/* File: tb/serial_eeprom_bus_slave_tb.sv */
// Bench: master and slave back to back, plus a second slave on a hand-driven link
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_bus_slave_tb;
   import seb_pkg::*;
   localparam int PROG = 1000;
   localparam int HALF = 8;
   typedef struct packed {
      logic [6:0] dev;
      logic [7:0] wadr;
      logic [7:0] wdat;
      logic wp;
      logic nack;
   } seb_row_t;
   seb_row_t rows [5] = '{
      '{{SEB_TYPE_CODE, 3'h0}, 8'h12, 8'hA5, 1'b0, 1'b0},
      '{{SEB_TYPE_CODE, 3'h1}, 8'hFF, 8'h3C, 1'b0, 1'b0},
      '{{SEB_TYPE_CODE, 3'h1}, 8'h00, 8'h5A, 1'b1, 1'b0},
      '{{SEB_TYPE_CODE, 3'h6}, 8'hFF, 8'h81, 1'b1, 1'b0},
      '{{~SEB_TYPE_CODE, 3'h0}, 8'h40, 8'h11, 1'b0, 1'b1}};
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic go_i = 1'b0;
   logic [6:0] dev_i = 7'h00;
   logic [7:0] wadr_i = 8'h00;
   logic [7:0] wdat_i = 8'h00;
   logic wp_i = 1'b0;
   logic stb, s_busy, m_busy, nack, b_stb, b_busy, s;
   logic [8:0] addr, b_addr, got_addr, b_got;
   logic [7:0] data, b_data, got_data, rd_byte;
   logic [7:0] rdat = 8'h96;
   int failures = 0;
   int cmp_count = 0;
   int stb_cnt = 0;
   int busy_cnt = 0;
   int b_cnt = 0;
   seb_if link ();
   seb_if link_b ();
   seb_slave #(.VARIANT(SEB_VAR_4K), .PROG_CYCLES(PROG)) seb_slave_inst (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus(link), .wp_i(wp_i),
      .wr_stb_o(stb), .wr_addr_o(addr), .wr_data_o(data), .busy_o(s_busy),
      .rd_req_o(), .rd_data_i(8'h00));
   seb_slave #(.VARIANT(SEB_VAR_4K), .PROG_CYCLES(PROG)) seb_slave_inst_b (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus(link_b), .wp_i(wp_i),
      .wr_stb_o(b_stb), .wr_addr_o(b_addr), .wr_data_o(b_data),
      .busy_o(b_busy), .rd_req_o(), .rd_data_i(rdat));
   seb_master #(.HALF(HALF)) seb_master_inst (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus(link), .go_i(go_i),
      .dev_i(dev_i), .wadr_i(wadr_i), .wdat_i(wdat_i), .busy_o(m_busy),
      .nack_o(nack));
   seb_checker #(.PROG_CYCLES(PROG)) seb_checker_inst (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .scl(link.scl),
      .sda(link.sda), .sda_m_oe_n(link.sda_m_oe_n),
      .sda_s_oe_n(link.sda_s_oe_n));
   initial link_b.scl = 1'b1;
   initial link_b.sda_m_oe_n = 1'b1;
   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      if (stb === 1'b1) begin
         stb_cnt++;
         got_addr = addr;
         got_data = data;
      end
      if (s_busy === 1'b1) busy_cnt++;
      if (b_stb === 1'b1) begin
         b_cnt++;
         b_got = {b_addr[8], b_data};
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tick
   task automatic close_out();
      if (failures == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_num(input int got, input int exp);
      chk_val((got == exp) ? 9'h001 : 9'h000, 9'h001);
   endtask : chk_num
   // Bounded wait for master (0) or slave (1) to go idle
   task automatic wait_low(input bit sel);
      int n;
      n = 0;
      while ((sel ? s_busy : m_busy) !== 1'b0 && n < 20000) begin
         tick(1);
         n++;
      end
      if (n == 20000) begin
         failures++;
         $display("FAIL %0t wait timed out", $time);
         close_out();
      end
   endtask : wait_low
   task automatic go(input seb_row_t r, input bit slow);
      dev_i <= r.dev;
      wadr_i <= r.wadr;
      wdat_i <= r.wdat;
      wp_i <= r.wp;
      go_i <= 1'b1;
      stb_cnt = 0;
      busy_cnt = 0;
      tick(1);
      go_i <= 1'b0;
      tick(8);
      wait_low(0);
      tick(8);
      if (slow) wait_low(1);
   endtask : go
   // Bit on the hand-driven link, sampled mid-high
   task automatic bb(input logic b);
      link_b.scl <= 1'b0;
      tick(HALF);
      link_b.sda_m_oe_n <= b;
      tick(HALF);
      link_b.scl <= 1'b1;
      tick(HALF);
      s = link_b.sda;
      tick(HALF);
   endtask : bb
   task automatic bb_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) bb(v[i]);
      bb(1'b1);
      chk_val({8'h00, s}, 9'h000);
   endtask : bb_byte
   initial begin
      tick(2);
      resetn_i <= 1'b1;
      tick(1);
      chk_val({7'h00, link.scl, link.sda}, 9'h003);
      foreach (rows[i]) begin
         go(rows[i], 1'b1);
         chk_val({8'h00, nack}, {8'h00, rows[i].nack});
         chk_num(stb_cnt, !rows[i].nack && !(rows[i].wp && rows[i].dev[0]));
         if (stb_cnt == 1) chk_val(got_addr, {rows[i].dev[0], rows[i].wadr});
         if (stb_cnt == 1) chk_val({1'b0, got_data}, {1'b0, rows[i].wdat});
         chk_num(busy_cnt, rows[i].nack ? 0 : PROG);
      end
      go(rows[0], 1'b0);
      go(rows[0], 1'b1);
      chk_val({8'h00, nack}, 9'h001);
      chk_num(stb_cnt, 0);
      go_i <= 1'b1;
      tick(1);
      go_i <= 1'b0;
      tick(300);
      resetn_i <= 1'b0;
      tick(2);
      chk_val({6'h00, m_busy, link.scl, link.sda}, 9'h003);
      resetn_i <= 1'b1;
      tick(2);
      link_b.sda_m_oe_n <= 1'b0;
      tick(HALF);
      bb(1'b1);
      bb(1'b0);
      bb(1'b1);
      link_b.sda_m_oe_n <= 1'b0;
      tick(HALF);
      bb_byte({SEB_TYPE_CODE, 3'h1, 1'b0});
      bb_byte(8'h7E);
      bb_byte(8'hC3);
      link_b.scl <= 1'b0;
      link_b.sda_m_oe_n <= 1'b0;
      tick(HALF);
      link_b.scl <= 1'b1;
      tick(HALF);
      link_b.sda_m_oe_n <= 1'b1;
      tick(HALF * 4);
      chk_num(b_cnt, 1);
      chk_val(b_got, 9'h1C3);
      // Read one byte once programming is over, master refuses more
      tick(PROG);
      link_b.sda_m_oe_n <= 1'b0;
      tick(HALF);
      bb_byte({SEB_TYPE_CODE, 3'h0, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         bb(1'b1);
         rd_byte[i] = s;
      end
      bb(1'b1);
      chk_val({1'b0, rd_byte}, 9'h096);
      link_b.scl <= 1'b0;
      link_b.sda_m_oe_n <= 1'b0;
      tick(HALF);
      link_b.scl <= 1'b1;
      tick(HALF);
      link_b.sda_m_oe_n <= 1'b1;
      tick(HALF * 4);
      chk_num(b_cnt, 1);
      chk_val({8'h00, b_busy}, 9'h000);
      close_out();
   end
endmodule : serial_eeprom_bus_slave_tb
`default_nettype wire
